// ===== bsie_pkg.sv
// shared types, constants and timing table for the bit and stack execution unit
package bsie_pkg;

  // one execution state is one i_mclk cycle (125 MHz, 8 ns)
  localparam int unsigned CLK_PERIOD_NS = 8;

  localparam int unsigned SP_W     = 8;
  localparam int unsigned BYTES_W  = 3;
  localparam int unsigned STATES_W = 5;
  localparam int unsigned XFER_W   = 3;

  localparam logic [SP_W-1:0] SP_RST = 8'h07;

  // extra states per operand class, and for a taken branch to an odd target
  localparam logic [STATES_W-1:0] PEN_RD_IO  = 5'h01;
  localparam logic [STATES_W-1:0] PEN_RD_SFR = 5'h02;
  localparam logic [STATES_W-1:0] PEN_WR_IO  = 5'h02;
  localparam logic [STATES_W-1:0] PEN_WR_SFR = 5'h03;
  localparam logic [STATES_W-1:0] PEN_HV_IO  = 5'h03;
  localparam logic [STATES_W-1:0] PEN_HV_SFR = 5'h05;
  localparam logic [STATES_W-1:0] PEN_BR_ODD = 5'h01;

  // bit instruction forms
  localparam logic [2:0] FORM_CARRY  = 3'h0;
  localparam logic [2:0] FORM_LEGACY = 3'h1;
  localparam logic [2:0] FORM_FULL   = 3'h2;
  // exchange forms
  localparam logic [2:0] FORM_BANK     = 3'h0;
  localparam logic [2:0] FORM_DIRECT   = 3'h1;
  localparam logic [2:0] FORM_INDIRECT = 3'h2;
  // stack forms
  localparam logic [2:0] FORM_STK_DIR   = 3'h0;
  localparam logic [2:0] FORM_STK_IMM8  = 3'h1;
  localparam logic [2:0] FORM_STK_IMM16 = 3'h2;
  localparam logic [2:0] FORM_STK_BYTE  = 3'h3;
  localparam logic [2:0] FORM_STK_WORD  = 3'h4;
  localparam logic [2:0] FORM_STK_DWORD = 3'h5;

  typedef enum logic [3:0] {
    BSIE_CLEAR_OP      = 4'h0,
    BSIE_SET_BIT_OP    = 4'h1,
    BSIE_INVERT_OP     = 4'h2,
    BSIE_AND_OP        = 4'h3,
    BSIE_AND_NOT_OP    = 4'h4,
    BSIE_OR_OP         = 4'h5,
    BSIE_OR_NOT_OP     = 4'h6,
    BSIE_MOVE_TO_CARRY = 4'h7,
    BSIE_MOVE_TO_BIT   = 4'h8,
    BSIE_EXCHANGE_OP   = 4'h9,
    BSIE_NIBBLE_XCHG   = 4'ha,
    BSIE_PUSH_OP       = 4'hb,
    BSIE_POP_OP        = 4'hc,
    BSIE_BRANCH_OP     = 4'hd
  } bsie_op_t;

  typedef enum logic [1:0] {
    BSIE_CLS_RAM = 2'h0,
    BSIE_CLS_IO  = 2'h1,
    BSIE_CLS_SFR = 2'h2
  } bsie_cls_t;

  typedef enum logic [1:0] {
    BSIE_PEN_NONE  = 2'h0,
    BSIE_PEN_READ  = 2'h1,
    BSIE_PEN_WRITE = 2'h2
  } bsie_pen_t;

  typedef struct packed {
    logic [BYTES_W-1:0]  bytes;
    logic [STATES_W-1:0] states;
    bsie_pen_t           pen;
    logic [XFER_W-1:0]   xfer;
  } bsie_timing_t;

  function automatic bsie_timing_t mk(input logic [2:0] b, input logic [4:0] s,
                                      input bsie_pen_t p, input logic [2:0] x);
    bsie_timing_t t;
    t.bytes  = b;
    t.states = s;
    t.pen    = p;
    t.xfer   = x;
    return t;
  endfunction

  // base length and states; src selects source mode
  function automatic bsie_timing_t timing(input bsie_op_t op, input logic [2:0] form,
                                          input logic src);
    bsie_timing_t t;
    t = mk(3'h1, 5'h01, BSIE_PEN_NONE, 3'h0);
    case (op)
      BSIE_CLEAR_OP, BSIE_SET_BIT_OP, BSIE_INVERT_OP, BSIE_MOVE_TO_BIT: begin
        case (form)
          FORM_CARRY:  t = mk(3'h1, 5'h01, BSIE_PEN_NONE, 3'h0);
          FORM_LEGACY: t = mk(3'h2, 5'h02, BSIE_PEN_WRITE, 3'h0);
          default:     t = src ? mk(3'h3, 5'h03, BSIE_PEN_WRITE, 3'h0)
                               : mk(3'h4, 5'h04, BSIE_PEN_WRITE, 3'h0);
        endcase
      end
      BSIE_AND_OP, BSIE_AND_NOT_OP, BSIE_OR_OP, BSIE_OR_NOT_OP, BSIE_MOVE_TO_CARRY: begin
        if (form == FORM_LEGACY) begin
          t = mk(3'h2, 5'h01, BSIE_PEN_READ, 3'h0);
        end else if (!src) begin
          t = mk(3'h4, 5'h03, BSIE_PEN_READ, 3'h0);
        end else if (op == BSIE_AND_NOT_OP) begin
          t = mk(3'h2, 5'h02, BSIE_PEN_READ, 3'h0);
        end else begin
          t = mk(3'h3, 5'h02, BSIE_PEN_READ, 3'h0);
        end
      end
      BSIE_EXCHANGE_OP: begin
        case (form)
          FORM_BANK:   t = src ? mk(3'h2, 5'h04, BSIE_PEN_NONE, 3'h0)
                               : mk(3'h1, 5'h03, BSIE_PEN_NONE, 3'h0);
          FORM_DIRECT: t = mk(3'h2, 5'h03, BSIE_PEN_WRITE, 3'h0);
          default:     t = src ? mk(3'h2, 5'h05, BSIE_PEN_NONE, 3'h0)
                               : mk(3'h1, 5'h04, BSIE_PEN_NONE, 3'h0);
        endcase
      end
      BSIE_NIBBLE_XCHG: begin
        t = src ? mk(3'h2, 5'h05, BSIE_PEN_NONE, 3'h0) : mk(3'h1, 5'h04, BSIE_PEN_NONE, 3'h0);
      end
      BSIE_PUSH_OP: begin
        case (form)
          FORM_STK_DIR:   t = mk(3'h2, 5'h02, BSIE_PEN_READ, 3'h1);
          FORM_STK_IMM8:  t = src ? mk(3'h3, 5'h03, BSIE_PEN_NONE, 3'h1)
                                  : mk(3'h4, 5'h04, BSIE_PEN_NONE, 3'h1);
          FORM_STK_IMM16: t = src ? mk(3'h4, 5'h05, BSIE_PEN_NONE, 3'h2)
                                  : mk(3'h5, 5'h05, BSIE_PEN_NONE, 3'h2);
          FORM_STK_BYTE:  t = src ? mk(3'h2, 5'h03, BSIE_PEN_NONE, 3'h1)
                                  : mk(3'h3, 5'h04, BSIE_PEN_NONE, 3'h1);
          FORM_STK_WORD:  t = src ? mk(3'h2, 5'h04, BSIE_PEN_NONE, 3'h2)
                                  : mk(3'h3, 5'h05, BSIE_PEN_NONE, 3'h2);
          default:        t = src ? mk(3'h2, 5'h08, BSIE_PEN_NONE, 3'h4)
                                  : mk(3'h3, 5'h09, BSIE_PEN_NONE, 3'h4);
        endcase
      end
      BSIE_POP_OP: begin
        case (form)
          FORM_STK_DIR:  t = mk(3'h2, 5'h03, BSIE_PEN_READ, 3'h1);
          FORM_STK_BYTE: t = src ? mk(3'h2, 5'h02, BSIE_PEN_NONE, 3'h1)
                                 : mk(3'h3, 5'h03, BSIE_PEN_NONE, 3'h1);
          FORM_STK_WORD: t = src ? mk(3'h2, 5'h04, BSIE_PEN_NONE, 3'h2)
                                 : mk(3'h3, 5'h05, BSIE_PEN_NONE, 3'h2);
          default:       t = src ? mk(3'h2, 5'h08, BSIE_PEN_NONE, 3'h4)
                                 : mk(3'h3, 5'h09, BSIE_PEN_NONE, 3'h4);
        endcase
      end
      default: t = mk(3'h1, 5'h01, BSIE_PEN_NONE, 3'h0);
    endcase
    return t;
  endfunction

endpackage

// ===== bsie_stack_if.sv
// stack memory port between the execution unit and its stack ram
interface bsie_stack_if #(
  parameter int unsigned AW = 8
);
  logic          we;
  logic [AW-1:0] addr;
  logic [7:0]    wdata;
  logic [7:0]    rdata;

  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem  (input we, input addr, input wdata, output rdata);
endinterface

// ===== bsie_stack_mem.sv
// byte-wide stack ram with registered read data
module bsie_stack_mem #(
  parameter int unsigned AW = 8
) (
  input  wire logic     i_mclk,
  bsie_stack_if.mem     port
);
  logic [7:0] mem_r [0:(1<<AW)-1];
  logic [7:0] rdata_r;

  always_ff @(posedge i_mclk) begin
    if (port.we) begin
      mem_r[port.addr] <= port.wdata;
    end
    rdata_r <= mem_r[port.addr];
  end

  assign port.rdata = rdata_r;
endmodule

// ===== bsie_exec.sv
// execution unit for bit, exchange, push and pop instructions
// How it works
// - set forces target bit or carry to one; lengths 1/1, 2/2, 4/4 or 3/3.
// - invert complements target bit or carry; same lengths and states as set.
// - and-to-carry makes carry AND source bit; 2/1, full 4/3 or 3/2.
// - and-not-to-carry makes carry AND NOT source; full 4/3 binary, 2/2 source.
// - or-to-carry makes carry OR source bit; 2/1, full 4/3 or 3/2.
// - or-not-to-carry makes carry OR NOT source; timing as plain or.
// - move to carry copies source bit to carry; 2/1, full 4/3 or 3/2.
// - move carry to bit writes carry to target; 2/2, full 4/4 or 3/3.
// - read-type penalty adds one state for io port, two for peripheral register.
// - write-type penalty adds two states for io port, three for peripheral register.
// - exchange swaps accumulator and operand; bank, direct and indirect timings.
// - nibble exchange swaps low nibbles with indirect location; 1/4 or 2/5.
// - push of direct and immediate operands with their lengths and states.
// - push of byte, word and double word registers with their lengths and states.
// - pop of direct, byte, word and double word with their lengths and states.
// - heavy penalty adds three states for io port, five for peripheral register.
// - taken internal branch to odd internal target adds one state.
module bsie_exec #(
  parameter int unsigned SP_AW = bsie_pkg::SP_W
) (
  input  wire logic                           i_mclk,
  input  wire logic                           i_sys_rst,
  input  wire logic                           i_start,
  input  wire bsie_pkg::bsie_op_t             i_op,
  input  wire logic [2:0]                     i_form,
  input  wire logic                           i_src_mode,
  input  wire bsie_pkg::bsie_cls_t            i_opnd_cls,
  input  wire logic                           i_heavy_pen,
  input  wire logic                           i_bit_in,
  input  wire logic [7:0]                     i_accumulator,
  input  wire logic [7:0]                     i_opnd,
  input  wire logic [31:0]                    i_push_data,
  input  wire logic [bsie_pkg::STATES_W-1:0]  i_br_base_states,
  input  wire logic                           i_br_taken,
  input  wire logic                           i_internal_exec,
  input  wire logic                           i_br_dest_internal,
  input  wire logic                           i_br_dest_odd,
  output logic                                o_busy,
  output logic                                o_done,
  output logic [bsie_pkg::BYTES_W-1:0]        o_bytes,
  output logic [bsie_pkg::STATES_W-1:0]       o_states,
  output logic                                o_carry_flag,
  output logic                                o_bit_we,
  output logic                                o_bit_out,
  output logic                                o_acc_we,
  output logic [7:0]                          o_accumulator,
  output logic                                o_opnd_we,
  output logic [7:0]                          o_opnd_out,
  output logic                                o_pop_we,
  output logic [31:0]                         o_pop_data,
  output logic [SP_AW-1:0]                    o_sp
);
  typedef enum logic [0:0] {
    BSIE_ST_IDLE = 1'b0,
    BSIE_ST_EXEC = 1'b1
  } bsie_state_t;

  bsie_stack_if #(.AW(SP_AW)) stk ();

  bsie_stack_mem #(.AW(SP_AW)) u_mem (
    .i_mclk (i_mclk),
    .port   (stk)
  );

  bsie_state_t                    state_r,    state_nxt;
  logic [bsie_pkg::STATES_W-1:0]  cnt_r,      cnt_nxt;
  logic [bsie_pkg::XFER_W-1:0]    left_r,     left_nxt;
  logic [1:0]                     idx_r,      idx_nxt;
  logic                           pend_r,     pend_nxt;
  logic                           push_r,     push_nxt;
  logic                           pop_op_r,   pop_op_nxt;
  logic [31:0]                    pdata_r,    pdata_nxt;
  logic [31:0]                    pop_r,      pop_nxt;
  logic [SP_AW-1:0]               sp_r,       sp_nxt;
  logic                           carry_r,    carry_nxt;
  logic                           cres_r,     cres_nxt;
  logic                           cwe_r,      cwe_nxt;
  logic                           bit_r,      bit_nxt;
  logic                           bwe_r,      bwe_nxt;
  logic [7:0]                     acc_r,      acc_nxt;
  logic [7:0]                     opo_r,      opo_nxt;
  logic                           xwe_r,      xwe_nxt;
  logic                           popwe_r,    popwe_nxt;
  logic                           done_r,     done_nxt;
  logic [bsie_pkg::BYTES_W-1:0]   bytes_r,    bytes_nxt;
  logic [bsie_pkg::STATES_W-1:0]  states_r,   states_nxt;

  bsie_pkg::bsie_timing_t         tim;
  logic [bsie_pkg::STATES_W-1:0]  pen;
  logic [bsie_pkg::STATES_W-1:0]  total;
  logic                           finish;
  logic                           is_io;
  logic                           is_carry_form;

  always_comb begin
    tim = bsie_pkg::timing(i_op, i_form, i_src_mode);
    pen = '0;
    if (i_heavy_pen) begin
      pen = is_io ? bsie_pkg::PEN_HV_IO : bsie_pkg::PEN_HV_SFR;
    end else if (tim.pen == bsie_pkg::BSIE_PEN_READ) begin
      pen = is_io ? bsie_pkg::PEN_RD_IO : bsie_pkg::PEN_RD_SFR;
    end else if (tim.pen == bsie_pkg::BSIE_PEN_WRITE) begin
      pen = is_io ? bsie_pkg::PEN_WR_IO : bsie_pkg::PEN_WR_SFR;
    end
    if (!is_io && i_opnd_cls != bsie_pkg::BSIE_CLS_SFR) begin
      pen = '0;
    end
    if (i_op == bsie_pkg::BSIE_BRANCH_OP) begin
      total = i_br_base_states;
      if (i_br_taken && i_internal_exec && i_br_dest_internal && i_br_dest_odd) begin
        total = i_br_base_states + bsie_pkg::PEN_BR_ODD;
      end
    end else begin
      total = tim.states + pen;
    end
    if (total == '0) begin
      total = 5'h01;
    end
  end

  assign is_carry_form = (i_form == bsie_pkg::FORM_CARRY);
  assign is_io         = (i_opnd_cls == bsie_pkg::BSIE_CLS_IO);
  assign finish        = (state_r == BSIE_ST_EXEC) && (cnt_r == '0) && (left_r == '0);

  // operand results are latched at start and released with the done pulse
  always_comb begin
    cres_nxt  = cres_r;
    cwe_nxt   = cwe_r;
    bit_nxt   = bit_r;
    bwe_nxt   = bwe_r;
    acc_nxt   = acc_r;
    opo_nxt   = opo_r;
    xwe_nxt   = xwe_r;
    if (state_r == BSIE_ST_IDLE && i_start) begin
      cres_nxt = carry_r;
      cwe_nxt  = 1'b0;
      bit_nxt  = i_bit_in;
      bwe_nxt  = 1'b0;
      acc_nxt  = i_accumulator;
      opo_nxt  = i_opnd;
      xwe_nxt  = 1'b0;
      case (i_op)
        bsie_pkg::BSIE_CLEAR_OP, bsie_pkg::BSIE_SET_BIT_OP, bsie_pkg::BSIE_INVERT_OP: begin
          cwe_nxt = is_carry_form;
          bwe_nxt = ~is_carry_form;
          if (i_op == bsie_pkg::BSIE_SET_BIT_OP) begin
            cres_nxt = 1'b1;
            bit_nxt  = 1'b1;
          end else if (i_op == bsie_pkg::BSIE_INVERT_OP) begin
            cres_nxt = ~carry_r;
            bit_nxt  = ~i_bit_in;
          end else begin
            cres_nxt = 1'b0;
            bit_nxt  = 1'b0;
          end
        end
        bsie_pkg::BSIE_AND_OP: begin
          cres_nxt = carry_r & i_bit_in;
          cwe_nxt  = 1'b1;
        end
        bsie_pkg::BSIE_AND_NOT_OP: begin
          cres_nxt = carry_r & ~i_bit_in;
          cwe_nxt  = 1'b1;
        end
        bsie_pkg::BSIE_OR_OP: begin
          cres_nxt = carry_r | i_bit_in;
          cwe_nxt  = 1'b1;
        end
        bsie_pkg::BSIE_OR_NOT_OP: begin
          cres_nxt = carry_r | ~i_bit_in;
          cwe_nxt  = 1'b1;
        end
        bsie_pkg::BSIE_MOVE_TO_CARRY: begin
          cres_nxt = i_bit_in;
          cwe_nxt  = 1'b1;
        end
        bsie_pkg::BSIE_MOVE_TO_BIT: begin
          bit_nxt = carry_r;
          bwe_nxt = 1'b1;
        end
        bsie_pkg::BSIE_EXCHANGE_OP: begin
          acc_nxt = i_opnd;
          opo_nxt = i_accumulator;
          xwe_nxt = 1'b1;
        end
        bsie_pkg::BSIE_NIBBLE_XCHG: begin
          acc_nxt = {i_accumulator[7:4], i_opnd[3:0]};
          opo_nxt = {i_opnd[7:4], i_accumulator[3:0]};
          xwe_nxt = 1'b1;
        end
        default: cwe_nxt = 1'b0;
      endcase
    end
  end

  always_comb begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    left_nxt   = left_r;
    idx_nxt    = idx_r;
    pend_nxt   = 1'b0;
    push_nxt   = push_r;
    pop_op_nxt = pop_op_r;
    pdata_nxt  = pdata_r;
    pop_nxt    = pop_r;
    sp_nxt     = sp_r;
    carry_nxt  = carry_r;
    popwe_nxt  = 1'b0;
    done_nxt   = 1'b0;
    bytes_nxt  = bytes_r;
    states_nxt = states_r;
    stk.we     = 1'b0;
    stk.addr   = sp_r;
    stk.wdata  = pdata_r[8*idx_r +: 8];
    if (pend_r) begin
      pop_nxt = {pop_r[23:0], stk.rdata};
    end
    case (state_r)
      BSIE_ST_IDLE: begin
        if (i_start) begin
          state_nxt  = BSIE_ST_EXEC;
          cnt_nxt    = total - 5'h01;
          states_nxt = total;
          bytes_nxt  = (i_op == bsie_pkg::BSIE_BRANCH_OP) ? 3'h0 : tim.bytes;
          idx_nxt    = '0;
          pdata_nxt  = i_push_data;
          pop_nxt    = '0;
          push_nxt   = (i_op == bsie_pkg::BSIE_PUSH_OP);
          pop_op_nxt = (i_op == bsie_pkg::BSIE_POP_OP);
          left_nxt   = (i_op == bsie_pkg::BSIE_PUSH_OP || i_op == bsie_pkg::BSIE_POP_OP)
                       ? tim.xfer : 3'h0;
        end
      end
      BSIE_ST_EXEC: begin
        if (cnt_r != '0) begin
          cnt_nxt = cnt_r - 5'h01;
        end
        if (left_r != '0) begin
          left_nxt = left_r - 3'h1;
          if (push_r) begin
            sp_nxt   = sp_r + 1'b1;
            stk.addr = sp_r + 1'b1;
            stk.we   = 1'b1;
            idx_nxt  = idx_r + 2'h1;
          end else begin
            stk.addr = sp_r;
            sp_nxt   = sp_r - 1'b1;
            pend_nxt = 1'b1;
          end
        end
        if (finish) begin
          state_nxt = BSIE_ST_IDLE;
          done_nxt  = 1'b1;
          popwe_nxt = pop_op_r;
          if (cwe_r) begin
            carry_nxt = cres_r;
          end
        end
      end
      default: begin
        state_nxt = BSIE_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      state_r  <= BSIE_ST_IDLE;
      cnt_r    <= '0;
      left_r   <= '0;
      idx_r    <= '0;
      pend_r   <= 1'b0;
      push_r   <= 1'b0;
      pop_op_r <= 1'b0;
      pdata_r  <= '0;
      pop_r    <= '0;
      sp_r     <= bsie_pkg::SP_RST;
      carry_r  <= 1'b0;
      cres_r   <= 1'b0;
      cwe_r    <= 1'b0;
      bit_r    <= 1'b0;
      bwe_r    <= 1'b0;
      acc_r    <= '0;
      opo_r    <= '0;
      xwe_r    <= 1'b0;
      popwe_r  <= 1'b0;
      done_r   <= 1'b0;
      bytes_r  <= '0;
      states_r <= '0;
    end else begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      left_r   <= left_nxt;
      idx_r    <= idx_nxt;
      pend_r   <= pend_nxt;
      push_r   <= push_nxt;
      pop_op_r <= pop_op_nxt;
      pdata_r  <= pdata_nxt;
      pop_r    <= pop_nxt;
      sp_r     <= sp_nxt;
      carry_r  <= carry_nxt;
      cres_r   <= cres_nxt;
      cwe_r    <= cwe_nxt;
      bit_r    <= bit_nxt;
      bwe_r    <= bwe_nxt;
      acc_r    <= acc_nxt;
      opo_r    <= opo_nxt;
      xwe_r    <= xwe_nxt;
      popwe_r  <= popwe_nxt;
      done_r   <= done_nxt;
      bytes_r  <= bytes_nxt;
      states_r <= states_nxt;
    end
  end

  assign o_busy        = (state_r == BSIE_ST_EXEC);
  assign o_done        = done_r;
  assign o_bytes       = bytes_r;
  assign o_states      = states_r;
  assign o_carry_flag  = carry_r;
  assign o_bit_we      = done_r & bwe_r;
  assign o_bit_out     = bit_r;
  assign o_acc_we      = done_r & xwe_r;
  assign o_accumulator = acc_r;
  assign o_opnd_we     = done_r & xwe_r;
  assign o_opnd_out    = opo_r;
  assign o_pop_we      = popwe_r;
  assign o_pop_data    = pop_r;
  assign o_sp          = sp_r;
endmodule

// ===== bsie_exec_assertions.sv
// concurrent checks on the execution unit ports
module bsie_exec_assertions #(
  parameter int unsigned SP_AW = bsie_pkg::SP_W
) (
  input wire logic                          i_mclk,
  input wire logic                          i_sys_rst,
  input wire logic                          i_start,
  input wire bsie_pkg::bsie_op_t            i_op,
  input wire logic [2:0]                    i_form,
  input wire logic                          o_busy,
  input wire logic                          o_done,
  input wire logic [bsie_pkg::STATES_W-1:0] o_states,
  input wire logic                          o_bit_we,
  input wire logic                          o_bit_out,
  input wire logic                          o_acc_we,
  input wire logic                          o_opnd_we,
  input wire logic                          o_pop_we,
  input wire logic [SP_AW-1:0]              o_sp
);
  logic [7:0]         cnt_r;
  bsie_pkg::bsie_op_t op_r;
  logic [2:0]         form_r;
  logic [SP_AW-1:0]   sp_r;
  // busy cycles of the running instruction and what it was started with
  always_ff @(posedge i_mclk) begin
    cnt_r <= (i_sys_rst || !o_busy) ? 8'h00 : cnt_r + 8'h01;
    if (i_start && !o_busy) begin
      op_r   <= i_op;
      form_r <= i_form;
      sp_r   <= o_sp;
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  a_start_busy: assert property (i_start && !o_busy |=> o_busy)
    else $error("start not taken");
  a_done_after: assert property (o_done |-> !o_busy && $past(o_busy))
    else $error("done without busy before it");
  a_done_pulse: assert property (o_done |=> !o_done)
    else $error("done longer than one cycle");
  a_busy_len: assert property (o_done |-> cnt_r == {3'h0, o_states})
    else $error("busy length differs from state count");
  a_we_done: assert property ((o_bit_we || o_acc_we || o_opnd_we || o_pop_we) |-> o_done)
    else $error("write strobe outside done");
  a_xchg_pair: assert property ((o_acc_we || o_opnd_we) |-> o_acc_we && o_opnd_we
    && op_r inside {bsie_pkg::BSIE_EXCHANGE_OP, bsie_pkg::BSIE_NIBBLE_XCHG})
    else $error("exchange strobes wrong");
  a_set_bit: assert property (o_bit_we && op_r == bsie_pkg::BSIE_SET_BIT_OP |-> o_bit_out)
    else $error("set wrote zero");
  a_clear_bit: assert property (o_bit_we && op_r == bsie_pkg::BSIE_CLEAR_OP |-> !o_bit_out)
    else $error("clear wrote one");
  a_push_sp: assert property (o_done && op_r == bsie_pkg::BSIE_PUSH_OP
    && form_r == bsie_pkg::FORM_STK_DWORD |-> o_sp - sp_r == SP_AW'(4))
    else $error("dword push moved pointer wrongly");
  a_pop_sp: assert property (o_done && op_r == bsie_pkg::BSIE_POP_OP
    && form_r == bsie_pkg::FORM_STK_DWORD |-> sp_r - o_sp == SP_AW'(4))
    else $error("dword pop moved pointer wrongly");
  c_pop: cover property (o_pop_we);
  c_set: cover property (o_bit_we && o_bit_out);
  c_xchg: cover property (o_acc_we);
  c_b2b: cover property (o_done && i_start);
endmodule

bind bsie_exec bsie_exec_assertions #(.SP_AW(SP_AW)) i_bsie_exec_assertions (
  .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_start(i_start), .i_op(i_op), .i_form(i_form),
  .o_busy(o_busy), .o_done(o_done), .o_states(o_states), .o_bit_we(o_bit_we),
  .o_bit_out(o_bit_out), .o_acc_we(o_acc_we), .o_opnd_we(o_opnd_we), .o_pop_we(o_pop_we),
  .o_sp(o_sp));

// ===== bsie_opnd_model.sv
// operand space model: one addressed bit and one operand byte
module bsie_opnd_model (
  input  wire logic       i_mclk,
  input  wire logic       i_load,
  input  wire logic       i_load_bit,
  input  wire logic [7:0] i_load_byte,
  input  wire logic       i_bit_we,
  input  wire logic       i_bit_wr,
  input  wire logic       i_byte_we,
  input  wire logic [7:0] i_byte_wr,
  output logic            o_bit,
  output logic [7:0]      o_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       bit_r = 1'b0;
  logic [7:0] byte_r = 8'h00;
  assign o_bit  = i_load ? i_load_bit : bit_r;
  assign o_byte = i_load ? i_load_byte : byte_r;
  always @(posedge i_mclk) begin
    if (i_load) begin
      bit_r  <= i_load_bit;
      byte_r <= i_load_byte;
    end else begin
      if (i_bit_we) bit_r <= i_bit_wr;
      if (i_byte_we) byte_r <= i_byte_wr;
    end
  end
endmodule

// ===== test_bit_and_stack_instr_exec.sv
// self-checking bench for the bit and stack execution unit
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_total++; \
  $display("BAD %0t got %0h exp %0h", $time, a, e); end end
module test_bit_and_stack_instr_exec;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_mclk = 0, i_sys_rst = 1, i_start = 0, i_src_mode = 0, i_heavy_pen = 0;
  logic ld = 0, ld_bit = 0, tk = 0, ie = 0, di = 0, od = 0;
  bsie_pkg::bsie_op_t  i_op = bsie_pkg::BSIE_CLEAR_OP;
  bsie_pkg::bsie_cls_t i_opnd_cls = bsie_pkg::BSIE_CLS_RAM;
  logic [2:0]  i_form = 3'h0;
  logic [7:0]  i_accumulator = 8'h00, ld_byte = 8'h00, o_accumulator, o_opnd_out, opnd;
  logic [31:0] i_push_data = 32'h0, o_pop_data;
  logic [4:0]  i_br_base_states = 5'h01, o_states;
  logic [2:0]  o_bytes;
  logic [7:0]  o_sp;
  logic o_busy, o_done, o_carry_flag, o_bit_we, o_bit_out, o_acc_we, o_opnd_we, o_pop_we;
  logic bit_in;
  int err_total = 0, total_checks = 0, cyc = 0, cy = 0, esp = 7;
  int seed = 32'h437ca169;
  logic [7:0] stk[$];

  bsie_exec i_bsie_exec (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_start(i_start),
    .i_op(i_op), .i_form(i_form), .i_src_mode(i_src_mode), .i_opnd_cls(i_opnd_cls),
    .i_heavy_pen(i_heavy_pen), .i_bit_in(bit_in), .i_accumulator(i_accumulator),
    .i_opnd(opnd), .i_push_data(i_push_data), .i_br_base_states(i_br_base_states),
    .i_br_taken(tk), .i_internal_exec(ie), .i_br_dest_internal(di), .i_br_dest_odd(od),
    .o_busy(o_busy), .o_done(o_done), .o_bytes(o_bytes), .o_states(o_states),
    .o_carry_flag(o_carry_flag), .o_bit_we(o_bit_we), .o_bit_out(o_bit_out),
    .o_acc_we(o_acc_we), .o_accumulator(o_accumulator), .o_opnd_we(o_opnd_we),
    .o_opnd_out(o_opnd_out), .o_pop_we(o_pop_we), .o_pop_data(o_pop_data), .o_sp(o_sp));
  bsie_opnd_model i_bsie_opnd_model (.i_mclk(i_mclk), .i_load(ld), .i_load_bit(ld_bit),
    .i_load_byte(ld_byte), .i_bit_we(o_bit_we), .i_bit_wr(o_bit_out),
    .i_byte_we(o_opnd_we), .i_byte_wr(o_opnd_out), .o_bit(bit_in), .o_byte(opnd));

  initial begin
    forever #4 i_mclk = ~i_mclk;
  end

  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      test_done();
    end
  end

  task test_done();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // pk: penalty kind, 0 none 1 read 2 write 3 heavy; op 13: pk forces odd branch
  task automatic run(input int o, f, s, b, st, pk);
    logic [31:0] ea, eo, ed, m;
    int pen, n, cls, eb;
    cls = ($random(seed) & 3) % 3;
    pen = (cls == 0 || pk == 0) ? 0 : (cls == 1) ? pk : pk + 1 + (pk == 3);
    eb = 2;
    i_op = bsie_pkg::bsie_op_t'(o);
    i_form = f[2:0];
    i_src_mode = s[0];
    i_opnd_cls = bsie_pkg::bsie_cls_t'(cls);
    i_heavy_pen = (pk == 3);
    ld = 1;
    ld_bit = $random(seed);
    ld_byte = $random(seed);
    i_accumulator = $random(seed);
    i_push_data = $random(seed);
    i_br_base_states = 5'h01 + 5'($random(seed) & 7);
    {tk, ie, di, od} = (pk != 0) ? 4'hf : 4'($random(seed));
    if (o == 13) begin
      st = i_br_base_states;
      pen = tk & ie & di & od;
    end
    i_start = 1;
    @(posedge i_mclk);
    #1;
    i_start = 0;
    ld = 0;
    for (int i = 0; i < 40 && o_done !== 1'b1; i++) begin
      @(posedge i_mclk);
      #1;
    end
    n = (f == 2 || f == 4) ? 2 : (f == 5) ? 4 : 1;
    case (o)
      0, 1: if (f == 0) cy = o; else eb = o;
      2: if (f == 0) cy = !cy; else eb = !ld_bit;
      3: cy = cy & ld_bit;
      4: cy = cy & !ld_bit;
      5: cy = cy | ld_bit;
      6: cy = cy | !ld_bit;
      7: cy = ld_bit;
      8: eb = cy;
      9: {ea, eo} = {24'h0, ld_byte, 24'h0, i_accumulator};
      10: {ea, eo} = {24'h0, i_accumulator[7:4], ld_byte[3:0], 24'h0, ld_byte[7:4],
        i_accumulator[3:0]};
      11: for (int k = 0; k < n; k++) stk.push_back(i_push_data[8*k+:8]);
      12: begin
        ed = 0;
        for (int k = 0; k < n; k++) ed = (ed << 8) | stk.pop_back();
      end
      default: ;
    endcase
    esp = esp + (o == 11 ? n : o == 12 ? -n : 0);
    m = 32'hffffffff >> (32 - 8 * n);
    `CHK(o_done, 1'b1)
    `CHK({o_bit_we, o_pop_we}, {eb < 2, o == 12})
    `CHK(o_bytes, 3'(b))
    `CHK(o_states, 5'(st + pen))
    `CHK(o_carry_flag, cy[0])
    if (eb < 2) `CHK(o_bit_out, eb[0])
    if (o == 9 || o == 10) `CHK({o_accumulator, o_opnd_out}, {ea[7:0], eo[7:0]})
    if (o == 11 || o == 12) `CHK(o_sp, esp[7:0])
    if (o == 12) `CHK(o_pop_data & m, ed & m)
    $display("test op %0d form %0d mode %0d done", o, f, s);
  endtask

  initial begin
    repeat (20) @(posedge i_mclk);
    #1;
    i_sys_rst = 0;
    `CHK(o_sp, 8'h07)
    repeat (2) begin
      run(1, 0, 0, 1, 1, 0);
      run(1, 1, 1, 2, 2, 2);
      run(1, 2, 0, 4, 4, 2);
      run(1, 2, 1, 3, 3, 2);
      run(2, 0, 1, 1, 1, 0);
      run(2, 2, 0, 4, 4, 2);
      run(0, 1, 0, 2, 2, 2);
      run(0, 0, 1, 1, 1, 0);
      run(3, 1, 0, 2, 1, 1);
      run(3, 2, 1, 3, 2, 1);
      run(4, 2, 0, 4, 3, 1);
      run(4, 2, 1, 2, 2, 1);
      run(5, 2, 0, 4, 3, 1);
      run(6, 1, 1, 2, 1, 1);
      run(7, 2, 1, 3, 2, 1);
      run(8, 1, 0, 2, 2, 2);
      run(8, 2, 0, 4, 4, 2);
      run(9, 0, 1, 2, 4, 0);
      run(9, 1, 0, 2, 3, 2);
      run(9, 2, 0, 1, 4, 0);
      run(9, 1, 1, 2, 3, 3);
      run(10, 2, 0, 1, 4, 0);
      run(10, 2, 1, 2, 5, 0);
      run(11, 0, 0, 2, 2, 1);
      run(11, 1, 0, 4, 4, 0);
      run(11, 2, 1, 4, 5, 0);
      run(11, 3, 0, 3, 4, 0);
      run(11, 4, 1, 2, 4, 0);
      run(11, 5, 0, 3, 9, 0);
      run(12, 5, 1, 2, 8, 0);
      run(12, 4, 0, 3, 5, 0);
      run(12, 3, 1, 2, 2, 0);
      run(12, 0, 0, 2, 3, 1);
      run(13, 0, 0, 0, 0, 1);
      run(13, 0, 0, 0, 0, 0);
    end
    test_done();
  end
endmodule
